// ==== dpot_pkg.sv ====
// Shared constants and types for the dual potentiometer register slave.
package dpot_pkg;
   localparam logic [3:0] ADDR_WIPER0   = 4'h0;
   localparam logic [3:0] ADDR_WIPER1   = 4'h1;
   localparam logic [3:0] ADDR_GP_FIRST = 4'h2;
   localparam logic [3:0] ADDR_GP_LAST  = 4'h6;
   localparam logic [3:0] ADDR_RSVD     = 4'h7;
   localparam logic [3:0] ADDR_ACCESS   = 4'h8;
   localparam logic [3:0] ADDR_FIRST    = 4'h0;
   localparam logic [7:0] WIPER_MID     = 8'h40;
   localparam int         ACC_VOL_BIT   = 7;
   localparam int         ACC_PDC_BIT   = 6;
   localparam int         ACC_WIP_BIT   = 5;
   localparam logic       ACC_VOL_RST   = 1'b0;
   localparam logic       ACC_PDC_RST   = 1'b1;
   // Device-type prefix of the identification byte; the value is arbitrary.
   localparam logic [3:0] DEVICE_TYPE   = 4'h5;
   localparam int         CORE_CLK_PERIOD_NS = 50;
   localparam int         NV_WRITE_TIME_MS   = 20;
   localparam int         NV_WRITE_CYCLES    = NV_WRITE_TIME_MS * 1000000 / CORE_CLK_PERIOD_NS;
   typedef enum logic [1:0] {C_BOOT0, C_BOOT1, C_BOOT2, C_RUN} dpot_boot_e;
   typedef enum logic [2:0] {L_IDLE, L_RX, L_ACK, L_TX, L_MACK} dpot_link_e;
endpackage : dpot_pkg

// ==== dpot_sync.sv ====
// Two-flop level synchroniser for a group of independent bits.
`timescale 1ns/100ps
`default_nettype none
module dpot_sync #(
   parameter int W = 1
) (
   input  wire logic         clk_in,  // Destination clock.
   input  wire logic [W-1:0] d_in,    // Levels from another domain.
   output logic      [W-1:0] q_out    // Synchronised levels.
);
   logic [W-1:0] meta_q;

   if (W < 1)
   begin : g_chk
      $error("dpot_sync: W must be at least 1");
   end

   always_ff @(posedge clk_in)
   begin
      meta_q <= d_in;
      q_out  <= meta_q;
   end
endmodule : dpot_sync
`default_nettype wire

// ==== dpot_nv_mem.sv ====
// Non-volatile byte store with registered read data.
`timescale 1ns/100ps
`default_nettype none
module dpot_nv_mem #(
   parameter int               DEPTH = 8,
   parameter int               WIDTH = 8,
   parameter logic [WIDTH-1:0] INIT  = 8'h40
) (
   input  wire logic [WIDTH-1:0]         wdata_in,  // Byte to commit.
   input  wire logic                     clk_in,    // Core clock.
   input  wire logic                     we_in,     // Commit strobe.
   input  wire logic [$clog2(DEPTH)-1:0] waddr_in,  // Commit address.
   input  wire logic [$clog2(DEPTH)-1:0] raddr_in,  // Read address.
   output logic      [WIDTH-1:0]         rdata_out  // Read data, one cycle later.
);
   // Contents survive reset, as the cells they model survive power loss.
   logic [WIDTH-1:0] mem_q [DEPTH] = '{default: INIT};

   if (DEPTH < 8 || (DEPTH & (DEPTH - 1)) != 0)
   begin : g_chk
      $error("dpot_nv_mem: DEPTH must be a power of two of at least 8");
   end

   always_ff @(posedge clk_in)
   begin
      if (we_in)
      begin
         mem_q[waddr_in] <= wdata_in;
      end
      rdata_out <= mem_q[raddr_in];
   end
endmodule : dpot_nv_mem
`default_nettype wire

// ==== dpot_regs.sv ====
// Two-wire slave register interface of a dual digital potentiometer.
// Summary of operation
// - Wiper tap code equals register value; zero is ground end, all ones supply end.
// - Reset places both wiper registers at midscale code.
// - After reset both wipers load from their stored initial values.
// - Address zero selects channel 0 wiper, address one channel 1.
// - Addresses 2-6 are stored bytes, 7 reserved, 8 access control.
// - Volatile-select bit steers addresses 0 and 1 to stored or wiper registers.
// - Writing an initial value also writes the matching wiper register.
// - Volatile-select bit resets to zero.
// - Power-down control bit at zero forces shutdown; it resets to one.
// - Normal operation needs both pin high and control bit set.
// - Shutdown opens resistor ends and grounds the wiper terminals.
// - Leaving shutdown restores old tap; registers remain unchanged.
// - Serial interface and all registers stay usable during shutdown.
// - Read-only write-in-progress flag shows a running stored-byte write.
// - Writes to wipers, initial values, access control refused while flag set.
// - Slave only; bytes travel most significant bit first.
// - Traffic ignored until START; no START during boot; data pin released.
// - STOP returns the interface to standby.
// - Acknowledge valid identification, address and written data bytes.
// - Identification byte: type prefix, address-select pins, direction bit.
// - Sample data on clock rise; change output data after clock fall.
// - Pointer advances after each data byte and wraps from 8 to 0.
// - Stored-byte write starts at STOP and lasts the write time.
// - Read is write-addressed, then repeated START with read direction.
`timescale 1ns/100ps
`default_nettype none
module dpot_regs
   import dpot_pkg::*;
#(
   parameter int NV_WRITE_CYCLES_P = NV_WRITE_CYCLES
) (
   input  wire logic       core_clk_in,           // Core clock, 20 MHz.
   input  wire logic       rst_n_in,              // Synchronous reset, active low.
   input  wire logic       link_clk_in,           // Bus sampling clock.
   input  wire logic       scl_in,                // Serial clock pin.
   input  wire logic       sda_in,                // Serial data pin level.
   output logic            sda_out,               // Serial data drive value, always low.
   output logic            sda_oe_out,            // Serial data drive enable.
   input  wire logic [2:0] address_select_pins_in,// Slave address straps.
   input  wire logic       power_down_pin_in,     // Power-down pin, low for shutdown.
   output logic      [6:0] wiper0_tap_out,        // Channel 0 tap code.
   output logic      [6:0] wiper1_tap_out,        // Channel 1 tap code.
   output logic            shutdown_out,          // Ends open, wipers grounded.
   output logic            write_in_progress_out  // Stored-byte write running.
);
   localparam int CNT_W = $clog2(NV_WRITE_CYCLES_P + 1);

   if (NV_WRITE_CYCLES_P < 1)
   begin : g_chk
      $error("dpot_regs: NV_WRITE_CYCLES_P must be at least 1");
   end

   // Link clock domain.
   logic [7:0] lsync;
   logic       scl3_q, sda3_q, rsp3_q;
   logic       rsp_tgl_q;
   logic [7:0] rsp_data_q;
   logic       booted_q;
   dpot_link_e st_q;
   logic [3:0] cnt_q, ptr_q;
   logic [7:0] sh_q, rd_q;
   logic [1:0] phase_q;
   logic       rw_q, ack_q;
   logic       req_tgl_q, req_wr_q, stop_tgl_q;
   logic [3:0] req_addr_q;
   logic [7:0] req_data_q;

   dpot_sync #(.W(8)) u_lsync (
      .clk_in (link_clk_in),
      .d_in   ({rst_n_in, scl_in, sda_in, address_select_pins_in, booted_q, rsp_tgl_q}),
      .q_out  (lsync)
   );

   logic       lrst_n, scl2, sda2, boot2, rsp2;
   logic [2:0] asel2;
   assign {lrst_n, scl2, sda2, asel2, boot2, rsp2} = lsync;

   function automatic logic [3:0] next_ptr(input logic [3:0] p);
      next_ptr = (p == ADDR_ACCESS) ? ADDR_FIRST : 4'(p + 4'h1);
   endfunction : next_ptr

   logic       scl_rise, scl_fall, start_c, stop_c, byte_done, id_ok, rd_go;
   logic [7:0] rx_byte;
   // Edges are taken from the second stage and its delayed copy only.
   assign scl_rise  = scl2 & ~scl3_q;
   assign scl_fall  = ~scl2 & scl3_q;
   assign start_c   = scl2 & scl3_q & sda3_q & ~sda2 & boot2;
   assign stop_c    = scl2 & scl3_q & ~sda3_q & sda2;
   assign rx_byte   = {sh_q[6:0], sda2};
   assign byte_done = (st_q == L_RX) && scl_rise && (cnt_q == 4'h7);
   assign id_ok     = (rx_byte[7:4] == DEVICE_TYPE) && (rx_byte[3:1] == asel2);
   assign rd_go     = (byte_done && phase_q == 2'd0 && id_ok && rx_byte[0])
                    || (st_q == L_TX && scl_fall && cnt_q == 4'h7);

   always_ff @(posedge link_clk_in)
   begin
      scl3_q <= scl2;
      sda3_q <= sda2;
      rsp3_q <= rsp2;
      sda_out <= 1'b0;
   end

   always_ff @(posedge link_clk_in)
   begin
      if (!lrst_n)
      begin
         rd_q <= 8'h00;
      end
      else if (rsp2 ^ rsp3_q)
      begin
         rd_q <= rsp_data_q;
      end
   end

   always_ff @(posedge link_clk_in)
   begin
      if (!lrst_n)
      begin
         st_q       <= L_IDLE;
         sda_oe_out <= 1'b0;
         cnt_q      <= 4'h0;
         ptr_q      <= ADDR_FIRST;
         sh_q       <= 8'h00;
         phase_q    <= 2'd0;
         rw_q       <= 1'b0;
         ack_q      <= 1'b0;
      end
      else if (start_c)
      begin
         st_q       <= L_RX;
         cnt_q      <= 4'h0;
         phase_q    <= 2'd0;
         sda_oe_out <= 1'b0;
      end
      else if (stop_c)
      begin
         st_q       <= L_IDLE;
         sda_oe_out <= 1'b0;
      end
      else
      begin
         case (st_q)
            L_RX:
            begin
               if (scl_rise)
               begin
                  sh_q  <= rx_byte;
                  cnt_q <= 4'(cnt_q + 4'h1);
               end
               if (byte_done)
               begin
                  phase_q <= (phase_q == 2'd0) ? 2'd1 : 2'd2;
                  ack_q   <= (phase_q == 2'd0) ? id_ok : 1'b1;
                  if (phase_q == 2'd0)
                  begin
                     rw_q <= rx_byte[0];
                  end
                  else if (phase_q == 2'd1)
                  begin
                     ptr_q <= rx_byte[3:0];
                  end
                  else
                  begin
                     ptr_q <= next_ptr(ptr_q);
                  end
               end
               if (scl_fall && cnt_q == 4'h8)
               begin
                  sda_oe_out <= ack_q;
                  st_q       <= ack_q ? L_ACK : L_IDLE;
               end
            end
            L_ACK:
            begin
               if (scl_fall)
               begin
                  cnt_q <= 4'h0;
                  if (rw_q && phase_q == 2'd1)
                  begin
                     st_q       <= L_TX;
                     sda_oe_out <= ~rd_q[7];
                     sh_q       <= {rd_q[6:0], 1'b0};
                  end
                  else
                  begin
                     st_q       <= L_RX;
                     sda_oe_out <= 1'b0;
                  end
               end
            end
            L_TX:
            begin
               if (scl_fall)
               begin
                  if (cnt_q == 4'h7)
                  begin
                     sda_oe_out <= 1'b0;
                     st_q       <= L_MACK;
                     cnt_q      <= 4'h0;
                     ptr_q      <= next_ptr(ptr_q);
                  end
                  else
                  begin
                     sda_oe_out <= ~sh_q[7];
                     sh_q       <= {sh_q[6:0], 1'b0};
                     cnt_q      <= 4'(cnt_q + 4'h1);
                  end
               end
            end
            L_MACK:
            begin
               if (scl_rise)
               begin
                  ack_q <= ~sda2;
               end
               if (scl_fall)
               begin
                  if (ack_q)
                  begin
                     st_q       <= L_TX;
                     sda_oe_out <= ~rd_q[7];
                     sh_q       <= {rd_q[6:0], 1'b0};
                  end
                  else
                  begin
                     st_q <= L_IDLE;
                  end
               end
            end
            default:
            begin
               st_q <= L_IDLE;
            end
         endcase
      end
   end

   // Requests travel as a toggle; fields stay put until the next request.
   always_ff @(posedge link_clk_in)
   begin
      if (!lrst_n)
      begin
         req_tgl_q  <= 1'b0;
         req_wr_q   <= 1'b0;
         req_addr_q <= ADDR_FIRST;
         req_data_q <= 8'h00;
         stop_tgl_q <= 1'b0;
      end
      else
      begin
         if (stop_c)
         begin
            stop_tgl_q <= ~stop_tgl_q;
         end
         if (byte_done && phase_q == 2'd2)
         begin
            req_tgl_q  <= ~req_tgl_q;
            req_wr_q   <= 1'b1;
            req_addr_q <= ptr_q;
            req_data_q <= rx_byte;
         end
         else if (rd_go)
         begin
            req_tgl_q  <= ~req_tgl_q;
            req_wr_q   <= 1'b0;
            req_addr_q <= byte_done ? ptr_q : next_ptr(ptr_q);
         end
      end
   end

   // Core clock domain.
   logic [2:0]       csync;
   logic             req3_q, stop3_q;
   dpot_boot_e       boot_q;
   logic             vol_q, pdc_q, wip_q, nv_pend_q, rd_pend_q;
   logic [CNT_W-1:0] wip_cnt_q;
   logic [3:0]       nv_addr_q;
   logic [7:0]       nv_data_q, mem_rd;
   logic [2:0]       mem_raddr;

   dpot_sync #(.W(3)) u_csync (
      .clk_in (core_clk_in),
      .d_in   ({req_tgl_q, stop_tgl_q, power_down_pin_in}),
      .q_out  (csync)
   );

   logic req_pulse, stop_pulse, pd2, wr_ok, wip_done;
   assign req_pulse  = csync[2] ^ req3_q;
   assign stop_pulse = csync[1] ^ stop3_q;
   assign pd2        = csync[0];
   // Stored bytes are refused too while busy, since only one write can be staged.
   assign wr_ok      = req_pulse && req_wr_q && boot_q == C_RUN && !wip_q;
   assign wip_done   = wip_q && wip_cnt_q == '0;
   assign mem_raddr  = (boot_q == C_BOOT0) ? ADDR_WIPER0[2:0] :
                       (boot_q == C_BOOT1) ? ADDR_WIPER1[2:0] : req_addr_q[2:0];

   function automatic logic is_nv(input logic [3:0] a);
      is_nv = (a <= ADDR_WIPER1 && !vol_q) || (a >= ADDR_GP_FIRST && a <= ADDR_GP_LAST);
   endfunction : is_nv

   function automatic logic [7:0] read_value(input logic [3:0] a);
      if (a == ADDR_WIPER0 && vol_q)
         read_value = {1'b0, wiper0_tap_out};
      else if (a == ADDR_WIPER1 && vol_q)
         read_value = {1'b0, wiper1_tap_out};
      else if (is_nv(a))
         read_value = mem_rd;
      else if (a == ADDR_ACCESS)
         read_value = {vol_q, pdc_q, wip_q, 5'h00};
      else
         read_value = 8'h00;
   endfunction : read_value

   dpot_nv_mem #(.DEPTH(8), .WIDTH(8), .INIT(WIPER_MID)) u_nv (
      .clk_in    (core_clk_in),
      .we_in     (wip_done),
      .waddr_in  (nv_addr_q[2:0]),
      .wdata_in  (nv_data_q),
      .raddr_in  (mem_raddr),
      .rdata_out (mem_rd)
   );

   always_ff @(posedge core_clk_in)
   begin
      req3_q  <= csync[2];
      stop3_q <= csync[1];
   end

   always_ff @(posedge core_clk_in)
   begin
      if (!rst_n_in)
      begin
         boot_q   <= C_BOOT0;
         booted_q <= 1'b0;
      end
      else
      begin
         booted_q <= (boot_q == C_RUN);
         case (boot_q)
            C_BOOT0: boot_q <= C_BOOT1;
            C_BOOT1: boot_q <= C_BOOT2;
            C_BOOT2: boot_q <= C_RUN;
            default: boot_q <= C_RUN;
         endcase
      end
   end

   // The tap code is the register itself, so shutdown never disturbs it.
   always_ff @(posedge core_clk_in)
   begin
      if (!rst_n_in)
      begin
         wiper0_tap_out <= WIPER_MID[6:0];
         wiper1_tap_out <= WIPER_MID[6:0];
      end
      else if (boot_q == C_BOOT1)
      begin
         wiper0_tap_out <= mem_rd[6:0];
      end
      else if (boot_q == C_BOOT2)
      begin
         wiper1_tap_out <= mem_rd[6:0];
      end
      else if (wr_ok && req_addr_q == ADDR_WIPER0)
      begin
         wiper0_tap_out <= req_data_q[6:0];
      end
      else if (wr_ok && req_addr_q == ADDR_WIPER1)
      begin
         wiper1_tap_out <= req_data_q[6:0];
      end
   end

   always_ff @(posedge core_clk_in)
   begin
      if (!rst_n_in)
      begin
         vol_q <= ACC_VOL_RST;
         pdc_q <= ACC_PDC_RST;
      end
      else if (wr_ok && req_addr_q == ADDR_ACCESS)
      begin
         vol_q <= req_data_q[ACC_VOL_BIT];
         pdc_q <= req_data_q[ACC_PDC_BIT];
      end
   end

   always_ff @(posedge core_clk_in)
   begin
      if (!rst_n_in)
      begin
         shutdown_out <= 1'b1;
      end
      else
      begin
         shutdown_out <= ~(pd2 & pdc_q);
      end
   end

   // Several stored-byte writes in one transfer leave only the last staged.
   always_ff @(posedge core_clk_in)
   begin
      if (!rst_n_in)
      begin
         nv_pend_q <= 1'b0;
         nv_addr_q <= ADDR_FIRST;
         nv_data_q <= 8'h00;
      end
      else if (wr_ok && is_nv(req_addr_q))
      begin
         nv_pend_q <= 1'b1;
         nv_addr_q <= req_addr_q;
         nv_data_q <= req_data_q;
      end
      else if (wip_done)
      begin
         nv_pend_q <= 1'b0;
      end
   end

   always_ff @(posedge core_clk_in)
   begin
      if (!rst_n_in)
      begin
         wip_q     <= 1'b0;
         wip_cnt_q <= '0;
      end
      else if (stop_pulse && nv_pend_q && !wip_q)
      begin
         wip_q     <= 1'b1;
         wip_cnt_q <= CNT_W'(NV_WRITE_CYCLES_P - 1);
      end
      else if (wip_done)
      begin
         wip_q <= 1'b0;
      end
      else if (wip_q)
      begin
         wip_cnt_q <= CNT_W'(wip_cnt_q - 1'b1);
      end
   end

   // Reads are served in all modes, shutdown included.
   always_ff @(posedge core_clk_in)
   begin
      if (!rst_n_in)
      begin
         rd_pend_q  <= 1'b0;
         rsp_tgl_q  <= 1'b0;
         rsp_data_q <= 8'h00;
      end
      else
      begin
         rd_pend_q <= req_pulse && !req_wr_q;
         if (rd_pend_q)
         begin
            rsp_data_q <= read_value(req_addr_q);
            rsp_tgl_q  <= ~rsp_tgl_q;
         end
      end
   end

   assign write_in_progress_out = wip_q;

   a_boot_mid: assert property (@(posedge core_clk_in) !rst_n_in |=> wiper0_tap_out == WIPER_MID[6:0])
      else $error("wiper not midscale after reset");
   a_boot_load: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
      boot_q == C_BOOT2 |=> wiper1_tap_out == $past(mem_rd[6:0]))
      else $error("wiper 1 not loaded from store");
   a_acc_reset: assert property (@(posedge core_clk_in) !rst_n_in |=> !vol_q && pdc_q)
      else $error("access control reset value wrong");
   a_pdc_shut: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
      !pdc_q |=> shutdown_out)
      else $error("control bit low without shutdown");
   a_both_run: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
      pd2 && pdc_q |=> !shutdown_out)
      else $error("shutdown with pin and bit both high");
   a_wip_lock: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
      wip_q && boot_q == C_RUN |=> $stable(vol_q) && $stable(pdc_q) && $stable(wiper0_tap_out))
      else $error("register changed during stored write");
   a_wip_cause: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
      $rose(wip_q) |-> $past(stop_pulse) && $past(nv_pend_q))
      else $error("write cycle without stop and staged byte");
   sequence s_initial_wiper_value_0_write;
      wr_ok && req_addr_q == ADDR_WIPER0 && !vol_q;
   endsequence
   a_ivr_copy: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
      s_initial_wiper_value_0_write |=> wiper0_tap_out == $past(req_data_q[6:0]) ##0 nv_pend_q)
      else $error("initial value not copied to wiper");
   a_ptr_wrap: assert property (@(posedge link_clk_in) disable iff (!lrst_n)
      st_q == L_TX && scl_fall && cnt_q == 4'h7 && ptr_q == ADDR_ACCESS && !start_c && !stop_c
      |=> ptr_q == ADDR_FIRST)
      else $error("pointer did not wrap");
   a_idle_free: assert property (@(posedge link_clk_in) disable iff (!lrst_n)
      st_q == L_IDLE |-> !sda_oe_out)
      else $error("data pin driven in standby");
endmodule : dpot_regs
`default_nettype wire

// ==== dpot_master.sv ====
// Behavioural two-wire bus master that drives the potentiometer slave.
`timescale 1ns/100ps
`default_nettype none
module dpot_master (
   output logic      scl_out,  // Serial clock, idle high.
   output logic      sda_out,  // Master data, high means released.
   input  wire logic sda_in    // Resolved wire level.
);
   // Each clock phase exceeds both the minimum low and high time.
   localparam int T = 1400;
   initial
   begin
      scl_out = 1'b1;
      sda_out = 1'b1;
   end
   // Also serves as a repeated start when the clock is low.
   task automatic start;
      sda_out = 1'b1;
      #T scl_out = 1'b1;
      #T sda_out = 1'b0;
      #T scl_out = 1'b0;
   endtask : start
   task automatic stop;
      sda_out = 1'b0;
      #T scl_out = 1'b1;
      #T sda_out = 1'b1;
      #T;
   endtask : stop
   // Sampling late in the high phase leaves the slave time to settle.
   task automatic bit_io(input logic b, output logic r);
      sda_out = b;
      #T scl_out = 1'b1;
      #T r = sda_in;
      scl_out = 1'b0;
   endtask : bit_io
   // Ninth bit: release to see the slave reply, or pull low to acknowledge a read byte.
   task automatic xfer(input logic [7:0] d, input logic ack_in, output logic [7:0] q, output logic ack);
      for (int i = 7; i >= 0; i--) bit_io(d[i], q[i]);
      bit_io(ack_in, ack);
   endtask : xfer
endmodule : dpot_master
`default_nettype wire

// ==== dpot_regs_tb.sv ====
// Self-checking bench of the dual potentiometer register slave.
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin failures++; \
   $display("[ERR] %0t got %h exp %h", $time, (a), (e)); end end
module dual_pot_i2c_register_slave_tb;
   import dpot_pkg::*;
   localparam logic [2:0] SEL = 3'h5;
   logic [2:0] asel;
   logic core_clk_in, link_clk_in, rst_n_in, pin, scl, sda_m, sda_oe, sda_d, write_in_progress, power_down_control;
   logic [6:0] tap0, tap1;
   wire logic sda_w = sda_m & ~(sda_oe & ~sda_d);
   int failures = 0, comparisons = 0, cycles = 0;
   logic [15:0] r;
   dpot_master M (.scl_out(scl), .sda_out(sda_m), .sda_in(sda_w));
   dpot_regs #(.NV_WRITE_CYCLES_P(8000)) DUT (.core_clk_in(core_clk_in), .rst_n_in(rst_n_in),
      .link_clk_in(link_clk_in), .scl_in(scl), .sda_in(sda_w), .sda_out(sda_d), .sda_oe_out(sda_oe),
      .address_select_pins_in(asel), .power_down_pin_in(pin), .wiper0_tap_out(tap0),
      .wiper1_tap_out(tap1), .shutdown_out(power_down_control), .write_in_progress_out(write_in_progress));
   initial
   begin
      core_clk_in = 1'b0;
      forever #25 core_clk_in = ~core_clk_in;
   end
   initial
   begin
      link_clk_in = 1'b0;
      #3.3;
      forever #7.5 link_clk_in = ~link_clk_in;
   end
   task automatic give_verdict;
      $display("comparisons %0d failures %0d", comparisons, failures);
      if (failures == 0 && comparisons > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask : give_verdict
   always @(posedge core_clk_in)
   begin
      cycles++;
      if (cycles == 90000)
      begin
         failures++;
         give_verdict();
      end
   end
   task automatic wr(input logic [7:0] a, input logic [15:0] d, input int n);
      logic [7:0] q;
      logic k;
      M.start();
      M.xfer({DEVICE_TYPE, SEL, 1'b0}, 1'b1, q, k);
      `CHK(k, 1'b0)
      M.xfer(a, 1'b1, q, k);
      `CHK(k, 1'b0)
      for (int i = 0; i < n; i++)
      begin
         M.xfer(d[15 - 8 * i -: 8], 1'b1, q, k);
         `CHK(k, 1'b0)
      end
      M.stop();
      repeat (10) @(negedge core_clk_in);
   endtask : wr
   task automatic rd(input logic [7:0] a, input int n);
      logic [7:0] q;
      logic k;
      r = 16'h0000;
      M.start();
      M.xfer({DEVICE_TYPE, SEL, 1'b0}, 1'b1, q, k);
      M.xfer(a, 1'b1, q, k);
      M.start();
      M.xfer({DEVICE_TYPE, SEL, 1'b1}, 1'b1, q, k);
      `CHK(k, 1'b0)
      for (int i = 0; i < n; i++)
      begin
         M.xfer(8'hff, i == n - 1, q, k);
         r = {r[7:0], q};
      end
      M.stop();
   endtask : rd
   task automatic t_boot;
      `CHK({tap0, tap1, power_down_control, write_in_progress}, {7'h40, 7'h40, 2'b00})
      rd(8'h08, 2);
      `CHK(r, 16'h4040)
   endtask : t_boot
   task automatic t_vol;
      wr(8'h08, 16'hc000, 1);
      wr(8'h00, 16'h156a, 2);
      `CHK({tap0, tap1}, {7'h15, 7'h6a})
      rd(8'h01, 2);
      `CHK(r, 16'h6a40)
      wr(8'h07, 16'h9900, 1);
      rd(8'h07, 1);
      `CHK(r, 16'h0000)
   endtask : t_vol
   task automatic t_power_down_control;
      wr(8'h08, 16'h8000, 1);
      `CHK({power_down_control, tap0}, {1'b1, 7'h15})
      wr(8'h01, 16'h3300, 1);
      `CHK(tap1, 7'h33)
      wr(8'h08, 16'hc000, 1);
      `CHK({power_down_control, tap0}, {1'b0, 7'h15})
      @(negedge core_clk_in) pin = 1'b0;
      repeat (10) @(negedge core_clk_in);
      `CHK(power_down_control, 1'b1)
      pin = 1'b1;
      repeat (10) @(negedge core_clk_in);
      `CHK({power_down_control, tap0}, {1'b0, 7'h15})
   endtask : t_power_down_control
   task automatic t_nv;
      wr(8'h08, 16'h4000, 1);
      wr(8'h00, 16'h2200, 1);
      `CHK({tap0, write_in_progress}, {7'h22, 1'b1})
      rd(8'h08, 1);
      `CHK(r[7:0], 8'h60)
      wr(8'h08, 16'hc000, 1);
      for (int i = 0; i < 9000 && write_in_progress !== 1'b0; i++) @(negedge core_clk_in);
      rd(8'h08, 2);
      `CHK(r, 16'h4022)
      wr(8'h03, 16'h5a00, 1);
      for (int i = 0; i < 9000 && write_in_progress !== 1'b0; i++) @(negedge core_clk_in);
      rd(8'h02, 2);
      `CHK(r, 16'h405a)
   endtask : t_nv
   // Store byte 0 now differs from midscale, so reset and reload can be told apart.
   task automatic t_reload;
      @(negedge core_clk_in) rst_n_in = 1'b0;
      repeat (3) @(negedge core_clk_in);
      `CHK({tap0, tap1, power_down_control, write_in_progress}, {7'h40, 7'h40, 2'b10})
      rst_n_in = 1'b1;
      repeat (20) @(negedge core_clk_in);
      `CHK({tap0, tap1, power_down_control}, {7'h22, 7'h40, 1'b0})
   endtask : t_reload
   task automatic t_badid;
      logic [7:0] q;
      logic k;
      M.start();
      M.xfer({DEVICE_TYPE, ~SEL, 1'b0}, 1'b1, q, k);
      `CHK(k, 1'b1)
      M.stop();
      @(negedge core_clk_in) asel = ~SEL;
      M.start();
      M.xfer({DEVICE_TYPE, SEL, 1'b0}, 1'b1, q, k);
      `CHK(k, 1'b1)
      M.stop();
      M.start();
      M.xfer({DEVICE_TYPE, ~SEL, 1'b0}, 1'b1, q, k);
      `CHK(k, 1'b0)
      M.stop();
   endtask : t_badid
   initial
   begin
      rst_n_in = 1'b0;
      pin = 1'b1;
      asel = SEL;
      repeat (3) @(negedge core_clk_in);
      rst_n_in = 1'b1;
      repeat (20) @(negedge core_clk_in);
      t_boot();
      t_vol();
      t_power_down_control();
      t_nv();
      t_reload();
      t_badid();
      give_verdict();
   end
endmodule : dual_pot_i2c_register_slave_tb
`default_nettype wire
